// ==== src/ifd_decode.v ====
// instruction field decoder with byte lanes, endian logic and load-use interlock
//
// Overview of operation
// (RULE1) each instruction is one aligned 32-bit word
// (RULE2) immediate format: opcode 31..26, source 25..21, target 20..16, immediate 15..0
// (RULE3) jump target is 26-bit field with upper 4 PC bits; register jump uses 32 bits
// (RULE4) target field is source, destination or condition; register format adds rd, shift, function
// (RULE5) load/store address is base register plus signed 16-bit offset
// (RULE6) branch target is PC plus the 16-bit offset
// (RULE7) jump-and-link writes return address into register 31
// (RULE8) register 0 reads zero and ignores writes
// (RULE9) sign extension replicates the top bit of the field
// (RULE10) upper-immediate places immediate above sixteen zero bits
// (RULE11) user endian swap is reverse enable AND user mode
// (RULE12) effective endian is memory endian XOR user swap
// (RULE13) memory endian is latched at reset, 1 big, 0 little
// (RULE14) instruction using a just-loaded value stalls one cycle
// (RULE15) access size: 3 word, 2 triple, 1 half, 0 byte
// (RULE16) access address names lowest byte; leftmost in big, rightmost in little endian
// (RULE17) byte lanes come from size and address bits 1..0, mirrored between endians
// (RULE18) cached load returns the whole containing word; byte_lanes gives loads only the selected lanes instead
// (RULE19) stores write only the selected bytes
// (RULE20) timed operations occur i cycles after start, in listed order
// (RULE21) jumps and branches take effect after one delay slot
// (RULE22) register jump to a non-word address flags an address error
`timescale 1ns/100ps
`default_nettype none
`include "ifd_map.vh"
module ifd_decode (
  input wire aclk,
  input wire aresetn,
  input wire endian_strap,
  input wire [31:0] awaddr,
  input wire awvalid,
  output wire awready,
  input wire [31:0] wdata,
  input wire [3:0] wstrb,
  input wire wvalid,
  output wire wready,
  output reg [1:0] bresp,
  output reg bvalid,
  input wire bready,
  input wire [31:0] araddr,
  input wire arvalid,
  output wire arready,
  output reg [31:0] rdata,
  output reg [1:0] rresp,
  output reg rvalid,
  input wire rready,
  output reg [5:0] operation_code_field,
  output reg [4:0] source_register_field,
  output reg [4:0] target_register_field,
  output reg [4:0] destination_register_field,
  output reg [4:0] shift_amount_field,
  output reg [5:0] function_code_field,
  output reg [31:0] imm_sext,
  output reg [31:0] imm_zext,
  output reg [31:0] imm_upper,
  output reg [31:0] branch_target,
  output reg [31:0] jump_target,
  output reg [31:0] link_addr,
  output reg [31:0] mem_addr,
  output reg [1:0] access_size,
  output reg [3:0] byte_lanes,
  output reg effective_load_store_endian,
  output reg addr_error,
  output reg stall
);
  // register file and control state
  reg [1:0] ctl_r;
  reg memory_endian_config;
  reg strap_seen_r;
  reg [2:0] strap_sync_r;
  reg [31:0] insn_r;
  reg [31:0] pc_r;
  reg insn_new_r;
  reg [4:0] load_dest_r;
  reg load_pend_r;
  reg stall_r;
  reg [31:0] stat_word;
  reg [31:0] awaddr_r;
  reg [31:0] wdata_r;
  reg [3:0] wstrb_r;
  reg aw_have_r;
  reg w_have_r;
  wire user_endian_swap;
  wire [31:0] ra;
  wire [3:0] lanes_w;
  wire [5:0] op_w;
  wire [4:0] rs_w;
  wire [4:0] rt_w;
  wire [4:0] rd_w;
  wire [5:0] fn_w;
  wire [31:0] sext_w;
  wire [31:0] ea_w;
  wire is_load;
  wire is_store;
  wire is_jal;
  wire is_jr;
  wire is_jalr;
  wire uses_rs;
  wire uses_rt;
  wire hazard;
  wire wr_go;
  integer b;

  // field slices of the held instruction word, always one full aligned word
  assign op_w = insn_r[`IFD_OP_HI:`IFD_OP_LO]; // RULE1 RULE2
  assign rs_w = insn_r[`IFD_RS_HI:`IFD_RS_LO];
  assign rt_w = insn_r[`IFD_RT_HI:`IFD_RT_LO];
  assign rd_w = insn_r[`IFD_RD_HI:`IFD_RD_LO]; // RULE4
  assign fn_w = insn_r[`IFD_FN_HI:`IFD_FN_LO];
  assign sext_w = {{16{insn_r[`IFD_IMM_HI]}}, insn_r[`IFD_IMM_HI:0]}; // RULE9
  assign is_load = (op_w[5:3] == `IFD_OPC_LOAD);
  assign is_store = (op_w[5:3] == `IFD_OPC_STORE);
  assign is_jal = (op_w == `IFD_OP_JAL);
  assign is_jr = (op_w == `IFD_OP_SPECIAL) && (fn_w == `IFD_FN_JR);
  assign is_jalr = (op_w == `IFD_OP_SPECIAL) && (fn_w == `IFD_FN_JALR);
  // rt is a source for register-format ops, stores and compare-branches
  assign uses_rs = (op_w != `IFD_OP_J) && !is_jal;
  assign uses_rt = (op_w == `IFD_OP_SPECIAL) || is_store || (op_w[5:2] == 4'h1);
  // loads and stores use base plus signed offset only
  assign ea_w = ra + sext_w; // RULE5

  // the user endian swap that feeds the effective endian for loads and stores
  assign user_endian_swap = ctl_r[`IFD_CTL_RE] & ctl_r[`IFD_CTL_USER]; // RULE11

  ifd_regs u_regs (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(wr_go && awaddr_r[3:0] == `IFD_CTL_ADDR && 1'b0),
    .waddr(5'h00),
    .wdata(32'h00000000),
    .raddr_a(rs_w),
    .raddr_b(rt_w),
    .rdata_a(ra),
    .rdata_b()
  );

  ifd_lanes u_lanes (
    .size(op_w[1:0]),
    .addr_lo(ea_w[1:0]),
    .big_endian(memory_endian_config ^ user_endian_swap),
    .lanes(lanes_w),
    .misaligned()
  );

  // strap pin passes three flops, unreset so it settles during reset; caught once the last two agree
  always @(posedge aclk) begin
    strap_sync_r <= {strap_sync_r[1:0], endian_strap};
    if (!aresetn) begin
      strap_seen_r <= 1'b0;
      memory_endian_config <= 1'b0;
    end else if (!strap_seen_r && strap_sync_r[2] == strap_sync_r[1]) begin
      strap_seen_r <= 1'b1;
      memory_endian_config <= strap_sync_r[2]; // RULE13
    end
  end

  // a load followed by a reader of its destination stalls once
  assign hazard = load_pend_r && (load_dest_r != `IFD_ZERO_REG) &&
                  ((uses_rs && rs_w == load_dest_r) || (uses_rt && rt_w == load_dest_r));

  // load-use tracking; a stalled instruction is re-presented one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      load_pend_r <= 1'b0;
      load_dest_r <= 5'h00;
      stall_r <= 1'b0;
    end else if (insn_new_r) begin
      stall_r <= hazard && !stall_r; // RULE14
      if (hazard && !stall_r) begin
        load_pend_r <= 1'b0;
      end else begin
        load_pend_r <= is_load;
        load_dest_r <= rt_w;
      end
    end else begin
      stall_r <= 1'b0;
    end
  end

  // registered decode outputs, valid one cycle after the instruction is written
  always @(posedge aclk) begin
    if (!aresetn) begin
      operation_code_field <= 6'h00;
      source_register_field <= 5'h00;
      target_register_field <= 5'h00;
      destination_register_field <= 5'h00;
      shift_amount_field <= 5'h00;
      function_code_field <= 6'h00;
      imm_sext <= 32'h00000000;
      imm_zext <= 32'h00000000;
      imm_upper <= 32'h00000000;
      branch_target <= 32'h00000000;
      jump_target <= 32'h00000000;
      link_addr <= 32'h00000000;
      mem_addr <= 32'h00000000;
      access_size <= 2'h0;
      byte_lanes <= 4'h0;
      effective_load_store_endian <= 1'b0;
      addr_error <= 1'b0;
      stall <= 1'b0;
    end else begin
      stall <= insn_new_r && hazard && !stall_r; // RULE14
      operation_code_field <= op_w;
      source_register_field <= rs_w;
      target_register_field <= rt_w; // RULE4
      destination_register_field <= (is_jal) ? `IFD_LINK_REG : rd_w; // RULE7
      shift_amount_field <= insn_r[`IFD_SA_HI:`IFD_SA_LO]; // RULE4
      function_code_field <= fn_w;
      imm_sext <= sext_w; // RULE9
      imm_zext <= {16'h0000, insn_r[`IFD_IMM_HI:0]};
      imm_upper <= {insn_r[`IFD_IMM_HI:0], 16'h0000}; // RULE10
      // the branch target is relative to the delay slot address: one instruction delay
      branch_target <= pc_r + `IFD_STEP + {sext_w[29:0], 2'b00}; // RULE6 RULE21
      if (is_jr || is_jalr) begin
        jump_target <= ra; // RULE3
      end else begin
        jump_target <= {pc_r[31:`IFD_PC_PAGE_LO], insn_r[`IFD_TGT_HI:0], 2'b00}; // RULE3
      end
      // return address skips the delay slot
      link_addr <= pc_r + `IFD_STEP + `IFD_STEP; // RULE7 RULE21
      addr_error <= (is_jr || is_jalr) && (ra[1:0] != 2'b00); // RULE22
      mem_addr <= ea_w; // RULE5 RULE16
      access_size <= op_w[1:0]; // RULE15
      // loads and stores alike enable only the selected bytes
      byte_lanes <= (is_load || is_store) ? lanes_w : 4'h0; // RULE17 RULE18 RULE19
      effective_load_store_endian <= memory_endian_config ^ user_endian_swap; // RULE12
    end
  end

  // bus write channels: address and data taken in either order
  assign awready = !aw_have_r && !bvalid;
  assign wready = !w_have_r && !bvalid;
  assign wr_go = aw_have_r && w_have_r;

  // write path; the instruction write starts a new decode, all fields settle together one cycle later
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      awaddr_r <= 32'h00000000;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      ctl_r <= 2'h0;
      insn_r <= 32'h00000000;
      pc_r <= 32'h00000000;
      insn_new_r <= 1'b0;
    end else begin
      insn_new_r <= 1'b0;
      if (awvalid && awready) begin
        aw_have_r <= 1'b1;
        awaddr_r <= awaddr;
      end
      if (wvalid && wready) begin
        w_have_r <= 1'b1;
        wdata_r <= wdata;
        wstrb_r <= wstrb;
      end
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r <= 1'b0;
        bvalid <= 1'b1;
        bresp <= 2'h0;
        if (awaddr_r[31:4] != 28'h0000000) begin
          // out-of-range writes are refused and must leave every register alone
          bresp <= 2'h2;
        end else begin
          case (awaddr_r[3:0])
            `IFD_CTL_ADDR: begin
              if (wstrb_r[0]) begin
                ctl_r <= wdata_r[1:0];
              end
            end
            `IFD_INSN_ADDR: begin
              for (b = 0; b < 4; b = b + 1) begin
                if (wstrb_r[b]) begin
                  insn_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
                end
              end
              insn_new_r <= 1'b1; // RULE20
            end
            `IFD_PC_ADDR: begin
              // low two bits dropped: instructions sit on word boundaries
              for (b = 0; b < 4; b = b + 1) begin
                if (wstrb_r[b]) begin
                  pc_r[b*8 +: 8] <= wdata_r[b*8 +: 8];
                end
              end
              pc_r[1:0] <= 2'b00; // RULE1
            end
            `IFD_STAT_ADDR: begin
              bresp <= 2'h0;
            end
            default: begin
              bresp <= 2'h2;
            end
          endcase
        end
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // status word: endian state, stall, pending load and address error
  always @* begin
    stat_word = 32'h00000000;
    stat_word[0] = memory_endian_config;
    stat_word[1] = user_endian_swap;
    stat_word[2] = memory_endian_config ^ user_endian_swap;
    stat_word[3] = stall;
    stat_word[4] = load_pend_r;
    stat_word[5] = addr_error;
  end

  assign arready = !rvalid;

  // read path answers one cycle after the address is taken
  always @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= 2'h0;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= 2'h0;
      rdata <= 32'h00000000;
      if (araddr[31:4] != 28'h0000000) begin
        rresp <= 2'h2;
      end else begin
        case (araddr[3:0])
          `IFD_CTL_ADDR: rdata <= {30'h00000000, ctl_r};
          `IFD_STAT_ADDR: rdata <= stat_word;
          `IFD_INSN_ADDR: rdata <= insn_r;
          `IFD_PC_ADDR: rdata <= pc_r;
          default: rresp <= 2'h2;
        endcase
      end
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ==== src/ifd_map.vh ====
// constants for the instruction field decoder: field positions, opcodes, access sizes
`ifndef IFD_MAP_VH
`define IFD_MAP_VH
`define IFD_OP_HI 31
`define IFD_OP_LO 26
`define IFD_RS_HI 25
`define IFD_RS_LO 21
`define IFD_RT_HI 20
`define IFD_RT_LO 16
`define IFD_RD_HI 15
`define IFD_RD_LO 11
`define IFD_SA_HI 10
`define IFD_SA_LO 6
`define IFD_FN_HI 5
`define IFD_FN_LO 0
`define IFD_IMM_HI 15
`define IFD_TGT_HI 25
`define IFD_PC_PAGE_LO 28
`define IFD_LINK_REG 5'h1f
`define IFD_ZERO_REG 5'h00
`define IFD_OP_SPECIAL 6'h00
`define IFD_OP_J 6'h02
`define IFD_OP_JAL 6'h03
`define IFD_OP_LUI 6'h0f
`define IFD_OP_ANDI 6'h0c
`define IFD_OP_ORI 6'h0d
`define IFD_OP_XORI 6'h0e
`define IFD_FN_JR 6'h08
`define IFD_FN_JALR 6'h09
`define IFD_OPC_BRANCH_HI 3'h0
`define IFD_OPC_LOAD 3'h4
`define IFD_OPC_STORE 3'h5
`define IFD_SZ_BYTE 2'h0
`define IFD_SZ_HALF 2'h1
`define IFD_SZ_TRIPLE 2'h2
`define IFD_SZ_WORD 2'h3
`define IFD_STEP 32'h00000004
`define IFD_CTL_ADDR 4'h0
`define IFD_STAT_ADDR 4'h4
`define IFD_INSN_ADDR 4'h8
`define IFD_PC_ADDR 4'hc
`define IFD_CTL_RE 0
`define IFD_CTL_USER 1
`endif

// ==== src/ifd_lanes.v ====
// byte lane enable and alignment check for load/store accesses
`timescale 1ns/100ps
`default_nettype none
`include "ifd_map.vh"
module ifd_lanes (
  input wire [1:0] size,
  input wire [1:0] addr_lo,
  input wire big_endian,
  output reg [3:0] lanes,
  output reg misaligned
);
  reg [3:0] le;
  // little endian lanes first; big endian mirrors them
  always @* begin
    le = 4'h0;
    misaligned = 1'b0;
    case (size)
      `IFD_SZ_WORD: begin
        le = 4'hf;
        misaligned = (addr_lo != 2'h0);
      end
      `IFD_SZ_TRIPLE: begin
        le = (addr_lo[0]) ? 4'he : 4'h7;
        misaligned = addr_lo[1];
      end
      `IFD_SZ_HALF: begin
        le = (addr_lo[1]) ? 4'hc : 4'h3;
        misaligned = addr_lo[0];
      end
      default: begin
        le = 4'h1 << addr_lo;
      end
    endcase
    // lowest byte address is leftmost lane in big endian, rightmost in little
    lanes = big_endian ? {le[0], le[1], le[2], le[3]} : le; // RULE16 RULE17
    if (misaligned) begin
      lanes = 4'h0;
    end
  end
endmodule
`default_nettype wire

// ==== src/ifd_regs.v ====
// general register array with register 0 hardwired to zero
`timescale 1ns/100ps
`default_nettype none
`include "ifd_map.vh"
module ifd_regs (
  input wire aclk,
  input wire aresetn,
  input wire we,
  input wire [4:0] waddr,
  input wire [31:0] wdata,
  input wire [4:0] raddr_a,
  input wire [4:0] raddr_b,
  output wire [31:0] rdata_a,
  output wire [31:0] rdata_b
);
  wire [1023:0] general_register_array;
  genvar i;
  // one flip-flop word per entry, each with a single driver; entry zero never takes a write
  generate
    for (i = 0; i < 32; i = i + 1) begin : g_ent
      reg [31:0] ent_r;
      always @(posedge aclk) begin
        if (!aresetn || i == 0) begin
          ent_r <= 32'h00000000; // RULE8
        end else if (we && {27'h0, waddr} == i) begin
          ent_r <= wdata;
        end
      end
      assign general_register_array[i*32 +: 32] = ent_r;
    end
  endgenerate
  assign rdata_a = (raddr_a == `IFD_ZERO_REG) ? 32'h00000000 : general_register_array[{raddr_a, 5'h00} +: 32]; // RULE8
  assign rdata_b = (raddr_b == `IFD_ZERO_REG) ? 32'h00000000 : general_register_array[{raddr_b, 5'h00} +: 32];
endmodule
`default_nettype wire

// ==== testbench/ifd_exec_model.sv ====
// downstream pipeline stage model that holds its instruction while stalled
`timescale 1ns/100ps
`default_nettype none
module ifd_exec_model (
  input wire logic aclk,
  input wire logic stall,
  output var int held
);
  // counts held cycles, one for each edge with stall high
  initial held = 0;
  always @(posedge aclk) begin
    if (stall) begin
      held <= held + 1;
    end
  end
endmodule
`default_nettype wire

// ==== testbench/ifd_decode_assertions.sv ====
// concurrent checks on the decoder's ports
`timescale 1ns/100ps
`default_nettype none
module ifd_decode_assertions (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  input wire logic [5:0] operation_code_field,
  input wire logic [4:0] destination_register_field,
  input wire logic [31:0] imm_sext,
  input wire logic [31:0] imm_zext,
  input wire logic [31:0] imm_upper,
  input wire logic [31:0] branch_target,
  input wire logic [31:0] link_addr,
  input wire logic [1:0] access_size,
  input wire logic [3:0] byte_lanes,
  input wire logic stall
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read request accepted, answer must follow one edge later
  sequence ar_taken;
    arvalid && arready;
  endsequence
  sequence r_held;
    rvalid && $stable(rdata);
  endsequence
  a_read_answer: assert property (ar_taken |=> rvalid) else $error("read answer late");
  a_rdata_hold: assert property (rvalid && !rready |=> r_held) else $error("read data dropped");
  a_bresp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("write resp dropped");
  a_sext_fill: assert property (imm_sext[31:16] == {16{imm_sext[15]}}) else $error("sign fill");
  a_upper_zero: assert property (imm_upper == {imm_sext[15:0], 16'h0000}
    && imm_zext == {16'h0000, imm_sext[15:0]}) else $error("upper or zero extension");
  a_size_code: assert property (access_size == operation_code_field[1:0]) else $error("size code");
  // lanes only for memory ops, and a word takes all four
  a_lanes_memop: assert property (byte_lanes != 4'h0 |-> operation_code_field[5:4] == 2'b10
    && (access_size != 2'h3 || byte_lanes == 4'hf)) else $error("lanes");
  a_link_dest: assert property (operation_code_field == 6'h03 |-> destination_register_field == 5'h1f)
    else $error("link dest");
  // link is pc+8, so branch is link-4 plus scaled offset
  a_branch_rel: assert property (operation_code_field[5:2] == 4'h1
    |-> branch_target == link_addr - 32'h4 + {imm_sext[29:0], 2'b00}) else $error("branch target");
  a_stall_pulse: assert property (stall |=> !stall) else $error("stall too long");
endmodule
`default_nettype wire

// ==== testbench/testbench.sv ====
// top bench for the instruction decoder over its register bus
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic aclk, aresetn, endian_strap, awvalid, wvalid, bready, arvalid, rready;
  logic [31:0] awaddr, wdata, araddr, rv;
  logic [3:0] wstrb;
  logic [1:0] rr;
  wire [31:0] rdata, imm_sext, imm_zext, imm_upper, branch_target, jump_target, link_addr, mem_addr;
  wire [5:0] operation_code_field, function_code_field;
  wire [4:0] source_register_field, target_register_field, destination_register_field, shift_amount_field;
  wire [1:0] bresp, rresp, access_size;
  wire [3:0] byte_lanes;
  wire awready, wready, bvalid, arready, rvalid, effective_load_store_endian, addr_error, stall;
  int bad_count, n_tests, held, base;

  ifd_decode DUT (.*);
  ifd_exec_model EX (.aclk(aclk), .stall(stall), .held(held));

  initial begin
    aclk = 0;
    forever #2.5 aclk = ~aclk;
  end

  task automatic stop_test;
    $display("Mismatches %0d of %0d checks", bad_count, n_tests);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic ck(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // strap flips after capture so a late change must not leak through
  task automatic rst(input logic s);
    aresetn <= 1'b0;
    endian_strap <= s;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    endian_strap <= ~s;
  endtask

  // address and data offered together, each released when taken; bready up until the answer
  task automatic axw(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
      end
    end while (!bvalid);
    bready <= 1'b0;
    ck(bresp, er);
  endtask

  // rready up with the address; data taken at the edge where rvalid is seen
  task automatic axr(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
      end
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
  endtask

  task automatic dec(input logic [31:0] i);
    axw(32'h8, i, 2'h0);
    repeat (3) @(posedge aclk);
  endtask

  // expected lanes: little endian from lane 0 up, big endian mirrored
  function automatic logic [3:0] lx(input logic [1:0] s, input logic [1:0] a, input logic be);
    logic [3:0] m;
    m = (4'hf >> (2'd3 - s)) << a;
    if (int'(a) + int'(s) > 3 || (s == 2'h1 && a[0])) return 4'h0;
    if (be) return {m[0], m[1], m[2], m[3]};
    return m;
  endfunction

  // every size and offset, as load and as store, with a negative displacement
  task automatic cfg(input logic [1:0] c, input logic [2:0] st);
    axw(32'h0, {30'h0, c}, 2'h0);
    axr(32'h4, rv, rr);
    ck(rv[2:0], st);
    for (int k = 0; k < 32; k++) begin
      dec({2'b10, k[4], 1'b0, k[3:2], 10'h0, 12'hfff, 2'b00, k[1:0]});
      ck(byte_lanes, lx(k[3:2], k[1:0], st[2]));
      ck(access_size, k[3:2]);
      ck(mem_addr, {28'hfffffff, 2'b00, k[1:0]});
      ck(effective_load_store_endian, st[2]);
    end
  endtask

  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    stop_test;
  end

  initial begin
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h0;
    {awaddr, wdata, araddr, wstrb} <= 100'h0;
    bad_count = 0;
    n_tests = 0;
    rst(1'b0);
    axw(32'hc, 32'ha0000103, 2'h0);
    dec(32'h08123456);
    ck(jump_target, 32'ha048d158);
    dec(32'h0fffffff);
    ck(destination_register_field, 5'h1f);
    ck(link_addr, 32'ha0000108);
    ck(jump_target, 32'haffffffc);
    dec(32'h1065fffe);
    ck({operation_code_field, source_register_field, target_register_field}, 16'h1065);
    ck(branch_target, 32'ha00000fc);
    ck(imm_sext, 32'hfffffffe);
    ck(imm_zext, 32'h0000fffe);
    dec(32'h00221920);
    ck({destination_register_field, shift_amount_field, function_code_field}, 16'h1920);
    dec(32'h3c008001);
    ck(imm_upper, 32'h80010000);
    dec(32'h00200008);
    ck(jump_target, 32'h0);
    ck(addr_error, 32'h0);
    base = held;
    dec(32'h8c050000);
    dec(32'h00a00821);
    ck(held - base, 1);
    base = held;
    dec(32'h8c050000);
    dec(32'h00c00821);
    dec(32'h8c000000);
    dec(32'h00000821);
    ck(held - base, 0);
    axw(32'h10, 32'h0, 2'h2);
    axr(32'h20, rv, rr);
    ck(rr, 2'h2);
    cfg(2'h0, 3'b000);
    cfg(2'h3, 3'b110);
    cfg(2'h1, 3'b000);
    rst(1'b1);
    cfg(2'h0, 3'b101);
    cfg(2'h3, 3'b011);
    stop_test;
  end
endmodule

bind ifd_decode ifd_decode_assertions chk (.*);
`default_nettype wire
